// ===== src/dht_pkg.sv
package dht_pkg;

	// Clock and tick timing
	localparam real CLK_PERIOD_NS = 10.0;
	localparam real TICK0_US      = 5.12;
	localparam real TICK1_US      = 100.0;
	localparam int  DIV12_CYC     = 12;
	localparam int  TICK0_CYC     = int'(TICK0_US * 1000.0 / CLK_PERIOD_NS);
	localparam int  TICK1_CYC     = int'(TICK1_US * 1000.0 / CLK_PERIOD_NS);
	localparam int  PRE_W         = 14;

	// Register addresses on the special function register port
	localparam logic [7:0] ADDR_CTRL    = 8'hC8;
	localparam logic [7:0] ADDR_CKSEL   = 8'hC9;
	localparam logic [7:0] ADDR_RELOAD_LO = 8'hCA;
	localparam logic [7:0] ADDR_RELOAD_HI = 8'hCB;
	localparam logic [7:0] ADDR_COUNT_LO  = 8'hCC;
	localparam logic [7:0] ADDR_COUNT_HI  = 8'hCD;

	// Reset values
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] CKSEL_RST = 8'h00;
	localparam logic [7:0] BYTE_RST  = 8'h00;
	localparam logic [7:0] BYTE_MAX  = 8'hFF;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// Control register bit positions
	localparam int CTRL_HI_FLAG  = 7;
	localparam int CTRL_LO_FLAG  = 6;
	localparam int CTRL_LO_IEN   = 5;
	localparam int CTRL_SPLIT    = 4;
	localparam int CTRL_HI_CAP   = 3;
	localparam int CTRL_LO_CAP   = 2;
	localparam int CTRL_HI_RUN   = 1;
	localparam int CTRL_LO_RUN   = 0;

	// Clock select field positions (low bit of each two-bit field)
	localparam int CKS_T2_HI = 6;
	localparam int CKS_T2_LO = 4;
	localparam int CKS_T1_HI = 2;
	localparam int CKS_T1_LO = 0;

	// Clock source encodings
	localparam logic [1:0] CKS_SYS   = 2'h0;
	localparam logic [1:0] CKS_DIV12 = 2'h1;
	localparam logic [1:0] CKS_TICK0 = 2'h2;
	localparam logic [1:0] CKS_TICK1 = 2'h3;

endpackage : dht_pkg

// ===== src/dht_timer.sv
`timescale 1ns/10ps
`default_nettype none

module dht_timer #(
	parameter int unsigned TICK1_CYCLES = dht_pkg::TICK1_CYC
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Special function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_rd,
	output logic      [7:0] sfr_rdata,
	// Capture events, one-cycle pulses
	input  wire logic       capture_low_evt,
	input  wire logic       capture_high_evt,
	// Interrupt request
	output logic            timer_irq,
	// Clock fields for the second timer
	output logic      [1:0] second_timer_high_clock_sel,
	output logic      [1:0] second_timer_low_clock_sel
);

	// Pick the tick that matches a clock select field
	function automatic logic sel_tick(
		input logic [1:0] sel,
		input logic       t_div,
		input logic       t_p0,
		input logic       t_p1
	);
		logic r;
		r = 1'b1;
		unique case (sel)
			dht_pkg::CKS_SYS:   r = 1'b1;
			dht_pkg::CKS_DIV12: r = t_div;
			dht_pkg::CKS_TICK0: r = t_p0;
			dht_pkg::CKS_TICK1: r = t_p1;
		endcase
		return r;
	endfunction : sel_tick

	// Address compare for a write strobe
	function automatic logic wr_hit(
		input logic       wr,
		input logic [7:0] addr,
		input logic [7:0] target
	);
		return wr && (addr == target);
	endfunction : wr_hit

	// Terminal counts; the prescalers never stop, so a tick's phase is free
	localparam logic [dht_pkg::PRE_W-1:0] DIV_LAST =
		dht_pkg::PRE_W'(dht_pkg::DIV12_CYC - 1);
	localparam logic [dht_pkg::PRE_W-1:0] P0_LAST =
		dht_pkg::PRE_W'(dht_pkg::TICK0_CYC - 1);
	localparam logic [dht_pkg::PRE_W-1:0] P1_LAST =
		dht_pkg::PRE_W'(TICK1_CYCLES - 1);
	localparam logic [dht_pkg::PRE_W-1:0] PRE_ZERO = '0;
	localparam logic [dht_pkg::PRE_W-1:0] PRE_ONE  = dht_pkg::PRE_W'(1);

	// Prescaler state
	logic [dht_pkg::PRE_W-1:0] div_cnt_r, div_cnt_nxt;
	logic [dht_pkg::PRE_W-1:0] p0_cnt_r,  p0_cnt_nxt;
	logic [dht_pkg::PRE_W-1:0] p1_cnt_r,  p1_cnt_nxt;
	logic                      tick_div, tick_p0, tick_p1;

	// Timer state
	logic [7:0] ctrl_r,   ctrl_nxt;
	logic [7:0] cksel_r,  cksel_nxt;
	logic [7:0] rld_lo_r, rld_lo_nxt;
	logic [7:0] rld_hi_r, rld_hi_nxt;
	logic [7:0] cnt_lo_r, cnt_lo_nxt;
	logic [7:0] cnt_hi_r, cnt_hi_nxt;
	logic [7:0] rdata_r,  rdata_nxt;

	// Free-running prescalers; ticks are one-cycle pulses on terminal count
	always_comb begin
		tick_div    = (div_cnt_r == DIV_LAST);
		tick_p0     = (p0_cnt_r == P0_LAST);
		tick_p1     = (p1_cnt_r == P1_LAST);

		// Wrap to zero so each tick repeats with its exact period
		div_cnt_nxt = tick_div ? PRE_ZERO : div_cnt_r + PRE_ONE;
		p0_cnt_nxt  = tick_p0 ? PRE_ZERO : p0_cnt_r + PRE_ONE;
		p1_cnt_nxt  = tick_p1 ? PRE_ZERO : p1_cnt_r + PRE_ONE;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_r <= '0;
			p0_cnt_r  <= '0;
			p1_cnt_r  <= '0;
		end else begin
			div_cnt_r <= div_cnt_nxt;
			p0_cnt_r  <= p0_cnt_nxt;
			p1_cnt_r  <= p1_cnt_nxt;
		end
	end

	// Write strobes, one per mapped register
	logic wr_ctrl;
	logic wr_cksel;
	logic wr_rld_lo;
	logic wr_rld_hi;
	logic wr_cnt_lo;
	logic wr_cnt_hi;

	// Decoded control fields and selected ticks
	logic split;
	logic cap_lo;
	logic cap_hi;
	logic run_lo;
	logic run_hi;
	logic tk_lo;
	logic tk_hi;

	// Incremented counts with their carry out
	logic [15:0] wide;
	logic [16:0] wide_inc;
	logic [8:0]  lo_inc;
	logic [8:0]  hi_inc;

	// Flag set requests from counting and capture
	logic set_h;
	logic set_l;

	// Register strobes; the address only counts together with the write strobe
	always_comb begin
		wr_ctrl   = wr_hit(sfr_wr, sfr_addr, dht_pkg::ADDR_CTRL);
		wr_cksel  = wr_hit(sfr_wr, sfr_addr, dht_pkg::ADDR_CKSEL);
		wr_rld_lo = wr_hit(sfr_wr, sfr_addr, dht_pkg::ADDR_RELOAD_LO);
		wr_rld_hi = wr_hit(sfr_wr, sfr_addr, dht_pkg::ADDR_RELOAD_HI);
		wr_cnt_lo = wr_hit(sfr_wr, sfr_addr, dht_pkg::ADDR_COUNT_LO);
		wr_cnt_hi = wr_hit(sfr_wr, sfr_addr, dht_pkg::ADDR_COUNT_HI);
	end

	// Control fields; the high-half bits only matter once split
	always_comb begin
		split  = ctrl_r[dht_pkg::CTRL_SPLIT];
		cap_lo = ctrl_r[dht_pkg::CTRL_LO_CAP];
		cap_hi = ctrl_r[dht_pkg::CTRL_HI_CAP];
		run_lo = ctrl_r[dht_pkg::CTRL_LO_RUN];
		run_hi = ctrl_r[dht_pkg::CTRL_HI_RUN];
		tk_lo  = sel_tick(cksel_r[dht_pkg::CKS_T1_LO +: 2],
			tick_div, tick_p0, tick_p1);
		tk_hi  = sel_tick(cksel_r[dht_pkg::CKS_T1_HI +: 2],
			tick_div, tick_p0, tick_p1);
	end

	// Incremented values, worked out once for every mode
	always_comb begin
		wide     = {cnt_hi_r, cnt_lo_r};
		wide_inc = {1'b0, wide} + 17'h1;
		lo_inc   = {1'b0, cnt_lo_r} + 9'h1;
		hi_inc   = {1'b0, cnt_hi_r} + 9'h1;
	end

	// Counting, capture, flags and register writes
	always_comb begin
		// Default: hold every register, no flag set
		set_h      = 1'b0;
		set_l      = 1'b0;
		ctrl_nxt   = ctrl_r;
		cksel_nxt  = cksel_r;
		rld_lo_nxt = rld_lo_r;
		rld_hi_nxt = rld_hi_r;
		cnt_lo_nxt = cnt_lo_r;
		cnt_hi_nxt = cnt_hi_r;

		if (!split) begin
			// Wide: low-half controls govern all 16 bits
			// Timer mode reloads on the 16-bit wrap; capture mode free-runs
			if (run_lo && tk_lo) begin
				{cnt_hi_nxt, cnt_lo_nxt} = wide_inc[15:0];
				if (cap_lo) begin
					set_l = wide_inc[16];
				end else begin
					set_l = lo_inc[8];
					if (wide_inc[16]) begin
						set_h      = 1'b1;
						cnt_lo_nxt = rld_lo_r;
						cnt_hi_nxt = rld_hi_r;
					end
				end
			end

			// High capture select and run bit are ignored here
			if (cap_lo && capture_low_evt) begin
				rld_lo_nxt = cnt_lo_r;
				rld_hi_nxt = cnt_hi_r;
				set_h      = 1'b1;
			end
		end else begin
			// Split: each half on its own clock, mode and run bit
			// Low half counts on its own tick
			if (run_lo && tk_lo) begin
				cnt_lo_nxt = lo_inc[7:0];
				if (!cap_lo && lo_inc[8]) begin
					set_l      = 1'b1;
					cnt_lo_nxt = rld_lo_r;
				end
			end

			// Low capture copies the count as it stood before this edge
			if (cap_lo && capture_low_evt) begin
				rld_lo_nxt = cnt_lo_r;
				set_l      = 1'b1;
			end

			// High half wraps to zero in capture mode, reloads in timer mode
			if (run_hi && tk_hi) begin
				cnt_hi_nxt = hi_inc[7:0];
				if (hi_inc[8]) begin
					set_h = 1'b1;
					if (!cap_hi) begin
						cnt_hi_nxt = rld_hi_r;
					end
				end
			end

			// High capture only exists while split
			if (cap_hi && capture_high_evt) begin
				rld_hi_nxt = cnt_hi_r;
				set_h      = 1'b1;
			end
		end

		// Software writes win for data, but a hardware set beats a flag clear
		if (wr_ctrl) begin
			ctrl_nxt = sfr_wdata;
		end
		if (wr_cksel) begin
			cksel_nxt = sfr_wdata;
		end

		// Reload bytes take effect at once, even over a capture
		if (wr_rld_lo) begin
			rld_lo_nxt = sfr_wdata;
		end
		if (wr_rld_hi) begin
			rld_hi_nxt = sfr_wdata;
		end

		// Count bytes override a same-cycle increment or reload
		if (wr_cnt_lo) begin
			cnt_lo_nxt = sfr_wdata;
		end
		if (wr_cnt_hi) begin
			cnt_hi_nxt = sfr_wdata;
		end

		// Hardware only ever sets the flags here; a control write can clear them
		if (set_h) begin
			ctrl_nxt[dht_pkg::CTRL_HI_FLAG] = 1'b1;
		end
		if (set_l) begin
			ctrl_nxt[dht_pkg::CTRL_LO_FLAG] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r   <= dht_pkg::CTRL_RST;
			cksel_r  <= dht_pkg::CKSEL_RST;
			rld_lo_r <= dht_pkg::BYTE_RST;
			rld_hi_r <= dht_pkg::BYTE_RST;
			cnt_lo_r <= dht_pkg::BYTE_RST;
			cnt_hi_r <= dht_pkg::BYTE_RST;
		end else begin
			ctrl_r   <= ctrl_nxt;
			cksel_r  <= cksel_nxt;
			rld_lo_r <= rld_lo_nxt;
			rld_hi_r <= rld_hi_nxt;
			cnt_lo_r <= cnt_lo_nxt;
			cnt_hi_r <= cnt_hi_nxt;
		end
	end

	// Registered read data; unmapped addresses and idle cycles return zero
	always_comb begin
		rdata_nxt = dht_pkg::READ_ZERO;
		if (sfr_rd) begin
			// Reads have no side effect on any flag
			unique case (sfr_addr)
				dht_pkg::ADDR_CTRL:      rdata_nxt = ctrl_r;
				dht_pkg::ADDR_CKSEL:     rdata_nxt = cksel_r;
				dht_pkg::ADDR_RELOAD_LO: rdata_nxt = rld_lo_r;
				dht_pkg::ADDR_RELOAD_HI: rdata_nxt = rld_hi_r;
				dht_pkg::ADDR_COUNT_LO:  rdata_nxt = cnt_lo_r;
				dht_pkg::ADDR_COUNT_HI:  rdata_nxt = cnt_hi_r;
				default:                 rdata_nxt = dht_pkg::READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= dht_pkg::READ_ZERO;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// Read data straight from its flop
	assign sfr_rdata = rdata_r;

	// Request is plain logic on the flags, so it drops with a clear at once
	assign timer_irq = ctrl_r[dht_pkg::CTRL_HI_FLAG] |
		(ctrl_r[dht_pkg::CTRL_LO_FLAG] & ctrl_r[dht_pkg::CTRL_LO_IEN]);

	// Second timer fields are only stored here and passed on
	assign second_timer_high_clock_sel = cksel_r[dht_pkg::CKS_T2_HI +: 2];
	assign second_timer_low_clock_sel  = cksel_r[dht_pkg::CKS_T2_LO +: 2];

endmodule : dht_timer

`default_nettype wire

// ===== tb/dht_timer_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checks on the register port, clock fields and request line
module dht_timer_chk #(
	parameter int unsigned TICK1_CYCLES = 20
) (
	// Clock, reset and register port
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	// Events and outputs
	input wire logic       capture_low_evt,
	input wire logic       capture_high_evt,
	input wire logic       timer_irq,
	input wire logic [1:0] second_timer_high_clock_sel,
	input wire logic [1:0] second_timer_low_clock_sel
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// Decoded strobes
	logic wr_ck;
	logic wr_ct;
	assign wr_ck = sfr_wr && (sfr_addr == dht_pkg::ADDR_CKSEL);
	assign wr_ct = sfr_wr && (sfr_addr == dht_pkg::ADDR_CTRL);
	a_hi_field_write: assert property (wr_ck |=> second_timer_high_clock_sel == $past(sfr_wdata[7:6]))
		else $error("second high clock field not written");
	a_lo_field_write: assert property (wr_ck |=> second_timer_low_clock_sel == $past(sfr_wdata[5:4]))
		else $error("second low clock field not written");
	a_fields_hold: assert property (!wr_ck |=> $stable({second_timer_high_clock_sel, second_timer_low_clock_sel}))
		else $error("clock fields changed without a write");
	a_cksel_read_back: assert property (sfr_rd && sfr_addr == dht_pkg::ADDR_CKSEL |=> sfr_rdata[7:4] == $past({second_timer_high_clock_sel, second_timer_low_clock_sel}))
		else $error("clock select read back wrong");
	a_ctrl_read_back: assert property (wr_ct ##1 (sfr_rd && !sfr_wr && sfr_addr == dht_pkg::ADDR_CTRL) |=> sfr_rdata[5:0] == $past(sfr_wdata[5:0], 2))
		else $error("control bits not read back");
	a_flag_write_irq: assert property (wr_ct && sfr_wdata[7] |=> timer_irq)
		else $error("high flag write gave no request");
	a_low_enable_irq: assert property (wr_ct && sfr_wdata[6:5] == 2'b11 |=> timer_irq)
		else $error("enabled low flag gave no request");
	a_irq_drop_write: assert property ($fell(timer_irq) |-> $past(wr_ct))
		else $error("request dropped without software");
	// Main scenarios seen
	c_irq: cover property (timer_irq);
	c_hw_set: cover property ($rose(timer_irq) && !$past(wr_ct));
	c_cksel_read: cover property (sfr_rd && sfr_addr == dht_pkg::ADDR_CKSEL);
endmodule : dht_timer_chk
bind dht_timer dht_timer_chk #(.TICK1_CYCLES(TICK1_CYCLES)) i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
	.sfr_rdata(sfr_rdata), .capture_low_evt(capture_low_evt), .capture_high_evt(capture_high_evt),
	.timer_irq(timer_irq), .second_timer_high_clock_sel(second_timer_high_clock_sel),
	.second_timer_low_clock_sel(second_timer_low_clock_sel));
`default_nettype wire

// ===== tb/tb_dht_timer.sv
`timescale 1ns/10ps
`default_nettype none
module tb_dht_timer;
	localparam int T1 = 20;
	logic       clk_sys   = 1'b0;
	logic       rst_n     = 1'b0;
	logic [7:0] sfr_addr  = 8'h00;
	logic       sfr_wr    = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic       sfr_rd    = 1'b0;
	logic [7:0] sfr_rdata;
	logic       cap_lo    = 1'b0;
	logic       cap_hi    = 1'b0;
	logic       timer_irq;
	logic [1:0] sel_hi;
	logic [1:0] sel_lo;
	logic [7:0] q;
	logic [7:0] q2;
	int         per;
	int         n_errors   = 0;
	int         num_checks = 0;
	// 100 MHz system clock
	always #5 clk_sys = ~clk_sys;
	dht_timer #(.TICK1_CYCLES(T1)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.capture_low_evt(cap_lo), .capture_high_evt(cap_hi), .timer_irq(timer_irq),
		.second_timer_high_clock_sel(sel_hi), .second_timer_low_clock_sel(sel_lo));
	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: byte %h, expected %h", $time, got, exp);
		end
	endtask : chk8
	task automatic chk1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask : chk1
	// One-cycle strobes; the idle cycle between calls keeps each signal single-driven per step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge clk_sys);
		sfr_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		@(posedge clk_sys);
		sfr_rd <= 1'b0;
		#1 v = sfr_rdata;
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		rd(a, q);
		chk8(q, exp);
	endtask : rdc
	task automatic pulse(input bit hi);
		@(posedge clk_sys);
		cap_hi <= hi;
		cap_lo <= !hi;
		@(posedge clk_sys);
		cap_hi <= 1'b0;
		cap_lo <= 1'b0;
	endtask : pulse
	// Watchdog, far beyond the expected run of about 4250 cycles
	initial begin
		#500_000;
		n_errors++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		print_verdict();
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		// Reset values, plus an unmapped byte that must stay zero
		for (int a = 8'hC7; a <= 8'hCD; a++) begin
			rdc(8'(a), 8'h00);
		end
		wr(8'hC7, 8'hFF);
		rdc(8'hC7, 8'h00);
		$display("test registers done");
		// Wide wrap: four run edges, FFFF then reload 1234 up to 1237
		wr(8'hCA, 8'h34);
		wr(8'hCB, 8'h12);
		rdc(8'hCA, 8'h34);
		wr(8'hCC, 8'hFF);
		wr(8'hCD, 8'hFF);
		wr(8'hC8, 8'h01);
		rdc(8'hC8, 8'hC1);
		wr(8'hC8, 8'h20);
		rdc(8'hCC, 8'h37);
		rdc(8'hCD, 8'h12);
		rdc(8'hC8, 8'h20);
		wr(8'hC8, 8'h40);
		#1 chk1(timer_irq, 1'b0);
		wr(8'hC8, 8'h60);
		#1 chk1(timer_irq, 1'b1);
		wr(8'hC8, 8'h00);
		rdc(8'hC8, 8'h00);
		$display("test wide timer done");
		// High run ignored when wide, then split high half reloads to 80 on overflow; set beats clear
		wr(8'hCC, 8'h10);
		wr(8'hCD, 8'hFE);
		wr(8'hCB, 8'h80);
		wr(8'hC8, 8'h02);
		wr(8'hC8, 8'h12);
		wr(8'hC8, 8'h10);
		rdc(8'hC8, 8'h90);
		rdc(8'hCD, 8'h80);
		rdc(8'hCC, 8'h10);
		// Wide capture while stopped; the high event must be ignored
		wr(8'hCC, 8'h78);
		wr(8'hCD, 8'h56);
		wr(8'hC8, 8'h04);
		pulse(1'b1);
		rdc(8'hC8, 8'h04);
		pulse(1'b0);
		rdc(8'hCA, 8'h78);
		rdc(8'hCB, 8'h56);
		rdc(8'hC8, 8'h84);
		$display("test split and capture done");
		// Each source over 1024 run edges; the unused high field differs on purpose
		for (int s = 0; s < 4; s++) begin
			per = (s == 0) ? 1 : (s == 1) ? dht_pkg::DIV12_CYC : (s == 2) ? dht_pkg::TICK0_CYC : T1;
			wr(8'hCC, 8'h00);
			wr(8'hCD, 8'h00);
			wr(8'hC9, {2'(s), 2'(s), ~2'(s), 2'(s)});
			wr(8'hC8, 8'h01);
			repeat (1022) @(posedge clk_sys);
			wr(8'hC8, 8'h00);
			rd(8'hCC, q2);
			rd(8'hCD, q);
			chk8({sel_hi, sel_lo, 4'h0}, {2'(s), 2'(s), 4'h0});
			chk1({q, q2} >= 16'(1024 / per) && {q, q2} <= 16'(1024 / per + 1), 1'b1);
		end
		$display("test clock select done");
		print_verdict();
	end
endmodule : tb_dht_timer
`default_nettype wire
